/* File: rtl/arinc_tx_pkg.sv */
// Constants and types shared by the serial command and transmit logic
package arinc_tx_pkg;

  // ===========================================================================
  // Op codes
  localparam logic [7:0] OP_MCLR    = 8'h01;
  localparam logic [7:0] OP_DIV_WR  = 8'h07;
  localparam logic [7:0] OP_SR_RD   = 8'h0a;
  localparam logic [7:0] OP_CR_RD   = 8'h0b;
  localparam logic [7:0] OP_DIV_RD  = 8'h0c;
  localparam logic [7:0] OP_FIFO_WR = 8'h0e;
  localparam logic [7:0] OP_CR_WR   = 8'h10;
  localparam logic [7:0] OP_FIFO_CL = 8'h11;
  localparam logic [7:0] OP_SEND    = 8'h12;

  // ===========================================================================
  // Serial field ends, counted in serial clocks within the field
  localparam logic [4:0] OP_LAST   = 5'h07;
  localparam logic [4:0] DIV_LAST  = 5'h07;
  localparam logic [4:0] CR_LAST   = 5'h0f;
  localparam logic [4:0] WORD_LAST = 5'h1f;

  // ===========================================================================
  // Register fields and reset values
  localparam int CLK_SRC_SEL     = 1;
  localparam int PARITY_ENABLE   = 3;
  localparam int PARITY_SENSE    = 9;
  localparam int RATE_SELECT     = 10;
  localparam int LABEL_ORDER     = 11;
  localparam int DRIVER_OFF      = 12;
  localparam int AUTO_SEND       = 13;
  localparam int FLAG_SELECT     = 14;
  localparam logic [15:0] CONFIG_RST  = 16'h0000;
  localparam logic [7:0]  DIVISOR_RST = 8'h01;

  // ===========================================================================
  // FIFO geometry and status levels
  localparam int         WORD_BITS  = 32;
  localparam int         FIFO_DEPTH = 32;
  localparam logic [5:0] HALF_LEVEL = 6'h10;
  localparam logic [5:0] FULL_LEVEL = 6'h20;

  // ===========================================================================
  // Line timing in reference clocks, and gap length in half bits
  localparam logic [5:0] HI_HALF_LAST = 6'h04;
  localparam logic [5:0] LO_HALF_LAST = 6'h27;
  localparam logic [4:0] LAST_BIT     = 5'h1f;
  localparam logic [2:0] GAP_LAST     = 3'h7;

  typedef enum logic [1:0] {TX_IDLE, TX_BIT, TX_GAP} tx_state_t;

endpackage

/* File: rtl/arinc_tx_spi_command_regs.sv */
// Serial command decoder, configuration registers, transmit FIFO and line sequencer
`timescale 1ns/100ps

// ===========================================================================
// Word FIFO with valid/ready on both sides
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       flush,
  input  wire logic                       in_valid,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            in_ready,
  output logic                            out_valid,
  output logic [WIDTH-1:0]                out_data,
  input  wire logic                       out_ready,
  output logic [$clog2(DEPTH):0]          level
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } fifo_t;

  fifo_t q;
  fifo_t d;
  logic  push;
  logic  pop;

  assign in_ready  = q.cnt < (AW+1)'(DEPTH);
  assign out_valid = q.cnt != '0;
  assign out_data  = q.mem[q.rp];
  assign level     = q.cnt;

  always_comb begin
    d    = q;
    push = in_valid & in_ready;
    pop  = out_valid & out_ready;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp        = q.wp + AW'(1);
    end
    if (pop) begin
      d.rp = q.rp + AW'(1);
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (rst || flush) begin
      d.wp  = '0;
      d.rp  = '0;
      d.cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  property p_full_refuses;
    @(posedge clk) disable iff (rst)
      (q.cnt == (AW+1)'(DEPTH)) && !flush |=> q.wp == $past(q.wp);
  endproperty
  a_full_refuses: assert property (p_full_refuses) else $error("FIFO took word while full");
endmodule

// ===========================================================================
// Overview of operation
// - Op 07 stores divisor; op 0C reads it
// - Only divisors 1,2,4,8,10 give divided clock
// - Reserved test op codes shift zeros out
// - Op 0A returns 8-bit status
// - Op 0B returns 16-bit configuration
// - Op 0E words fill FIFO in order
// - Op 10 loads 16-bit configuration
// - Op 11 empties FIFO after eighth bit
// - Op 12 starts sending only without auto-send
// - Bit 1 selects direct or divided reference
// - Bit 3 makes 32nd bit parity
// - Bit 9 selects odd or even parity
// - Bit 10 selects reference/10 or /80
// - Bit 11 sets label bit order
// - Bit 12 forces line outputs to null
// - Bit 13 sends whenever FIFO holds data and chip select is high
// - Flag pin shows empty or full
// - Unused status bits read zero
// - Empty bit set when all sent
// - Half bit set at 16 words
// - Full bit set at 32 words
// - Op code and data shift MSB first
// - Read data MSB on next falling edge
// - Op 01 clears FIFO, keeps configuration
// - Words ignored while FIFO full
module arinc_tx_spi_command_regs
  import arinc_tx_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic aclk,
  input  wire logic master_clear,
  output logic      so,
  output logic      fifo_flag_pin,
  output logic      line_out_pos,
  output logic      line_out_neg
);

  typedef struct packed {
    logic [2:0]     sck_s;
    logic [2:0]     aclk_s;
    logic [1:0]     cs_s;
    logic [1:0]     si_s;
    logic [1:0]     mc_s;
    logic [7:0]     op;
    logic           op_done;
    logic [4:0]     cnt;
    logic           wrap;
    logic [31:0]    sh;
    logic [15:0]    rd;
    logic           so;
    logic [15:0]    transmit_config;
    logic [7:0]     ref_clock_divisor;
    logic           go;
    logic           wr_valid;
    logic [31:0]    wr_data;
    logic           flush;
    logic           abort;
    tx_state_t      st;
    logic [7:0]     dcount;
    logic [5:0]     half;
    logic [4:0]     bidx;
    logic           first;
    logic           lead;
    logic [2:0]     gap;
    logic [31:0]    tx_sh;
    logic           pos;
    logic           neg;
    logic           flag;
  } state_t;

  state_t      q;
  state_t      d;
  logic [31:0] shift_in;
  logic        rise;
  logic        fall;
  logic        cs_act;
  logic        ref_tick;
  logic        arinc_tick;
  logic        div_ok;
  logic [5:0]  half_last;
  logic        half_end;
  logic        can_send;
  logic        pop;
  logic        busy;
  logic        empty_bit;
  logic        half_bit;
  logic        full_bit;
  logic [7:0]  fifo_status;
  logic        fifo_valid;
  logic [31:0] fifo_data;
  logic [5:0]  fifo_level;

  // Puts the label in line order and, with parity enabled, fills the 32nd bit
  function automatic logic [31:0] line_order(input logic [31:0] w, input logic [15:0] c);
    logic [31:0] a;
    a = w;
    for (int i = 0; i < 8; i++) begin
      a[i] = c[LABEL_ORDER] ? w[i] : w[7-i];
    end
    if (c[PARITY_ENABLE]) begin
      a[31] = (^a[30:0]) ^ ~c[PARITY_SENSE];
    end
    return a;
  endfunction

  word_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (q.flush),
    .in_valid  (q.wr_valid),
    .in_data   (q.wr_data),
    .in_ready  (),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (pop),
    .level     (fifo_level)
  );

  assign so            = q.so;
  assign fifo_flag_pin = q.flag;
  assign line_out_pos  = q.pos;
  assign line_out_neg  = q.neg;

  always_comb begin
    d           = q;
    d.sck_s     = {q.sck_s[1:0], sck};
    d.aclk_s    = {q.aclk_s[1:0], aclk};
    d.cs_s      = {q.cs_s[0], cs_n};
    d.si_s      = {q.si_s[0], si};
    d.mc_s      = {q.mc_s[0], master_clear};
    d.wr_valid  = 1'b0;
    d.flush     = 1'b0;
    d.abort     = 1'b0;
    shift_in    = {q.sh[30:0], q.si_s[1]};
    rise        = q.sck_s[1] & ~q.sck_s[2];
    fall        = ~q.sck_s[1] & q.sck_s[2];
    cs_act      = ~q.cs_s[1];
    ref_tick    = q.aclk_s[1] & ~q.aclk_s[2];
    busy        = q.st != TX_IDLE;
    empty_bit   = (fifo_level == '0) && !busy;
    half_bit    = fifo_level >= HALF_LEVEL;
    full_bit    = fifo_level == FULL_LEVEL;
    fifo_status = {2'b00, full_bit, half_bit, empty_bit, 3'b000};

    // ===========================================================================
    // Reference clock and bit timing
    div_ok = (q.ref_clock_divisor == 8'h01) || (q.ref_clock_divisor == 8'h02)
          || (q.ref_clock_divisor == 8'h04) || (q.ref_clock_divisor == 8'h08)
          || (q.ref_clock_divisor == 8'h0a);
    arinc_tick = 1'b0;
    if (!q.transmit_config[CLK_SRC_SEL]) begin
      arinc_tick = ref_tick;
    end else if (ref_tick && div_ok) begin
      if (q.dcount >= q.ref_clock_divisor - 8'h01) begin
        d.dcount   = '0;
        arinc_tick = 1'b1;
      end else begin
        d.dcount = q.dcount + 8'h01;
      end
    end
    half_last = q.transmit_config[RATE_SELECT] ? LO_HALF_LAST : HI_HALF_LAST;
    half_end  = arinc_tick && (q.half >= half_last);
    if (arinc_tick) begin
      d.half = half_end ? '0 : q.half + 6'h01;
    end

    // ===========================================================================
    // Line sequencer
    can_send = q.transmit_config[AUTO_SEND] ? ~cs_act : q.go;
    pop      = (q.st == TX_IDLE) && can_send && fifo_valid && !q.abort;
    unique case (q.st)
      TX_IDLE: begin
        if (pop) begin
          d.tx_sh = line_order(fifo_data, q.transmit_config);
          d.st    = TX_BIT;
          d.bidx  = '0;
          d.first = 1'b1;
          d.lead  = 1'b1;
          d.half  = '0;
        end else if (!fifo_valid) begin
          d.go = 1'b0;
        end
      end
      TX_BIT: begin
        // Line stays null until the bit clock runs, so a stopped clock sends nothing
        if (q.lead) begin
          if (arinc_tick) begin
            d.lead = 1'b0;
            d.half = '0;
          end
        end else if (half_end) begin
          if (q.first) begin
            d.first = 1'b0;
          end else if (q.bidx == LAST_BIT) begin
            d.st  = TX_GAP;
            d.gap = '0;
          end else begin
            d.bidx  = q.bidx + 5'h01;
            d.tx_sh = {1'b0, q.tx_sh[31:1]};
            d.first = 1'b1;
          end
        end
      end
      TX_GAP: begin
        if (half_end) begin
          if (q.gap == GAP_LAST) begin
            d.st = TX_IDLE;
          end else begin
            d.gap = q.gap + 3'h1;
          end
        end
      end
    endcase
    if (q.abort) begin
      d.st = TX_IDLE;
      d.go = 1'b0;
    end
    d.pos  = (q.st == TX_BIT) && q.first && !q.lead
          && !q.transmit_config[DRIVER_OFF] && q.tx_sh[0];
    d.neg  = (q.st == TX_BIT) && q.first && !q.lead
          && !q.transmit_config[DRIVER_OFF] && !q.tx_sh[0];
    d.flag = q.transmit_config[FLAG_SELECT] ? full_bit : empty_bit;

    // ===========================================================================
    // Serial command port
    if (!cs_act) begin
      d.cnt     = '0;
      d.op_done = 1'b0;
      d.wrap    = 1'b0;
      d.so      = 1'b0;
    end else if (rise) begin
      d.sh  = shift_in;
      d.cnt = q.cnt + 5'h01;
      if (!q.op_done) begin
        if (q.cnt == OP_LAST) begin
          d.op      = shift_in[7:0];
          d.op_done = 1'b1;
          d.cnt     = '0;
          unique case (shift_in[7:0])
            OP_MCLR: begin
              d.flush = 1'b1;
              d.abort = 1'b1;
              d.rd    = '0;
            end
            OP_FIFO_CL: begin
              d.flush = 1'b1;
              d.rd    = '0;
            end
            OP_SEND: begin
              if (!q.transmit_config[AUTO_SEND]) begin
                d.go = 1'b1;
              end
              d.rd = '0;
            end
            OP_SR_RD:  d.rd = {fifo_status, 8'h00};
            OP_CR_RD:  d.rd = q.transmit_config;
            OP_DIV_RD: d.rd = {q.ref_clock_divisor, 8'h00};
            default:   d.rd = '0;
          endcase
        end
      end else begin
        if (q.cnt == WORD_LAST) begin
          d.wrap = 1'b1;
        end
        unique case (q.op)
          OP_DIV_WR: begin
            if (!q.wrap && q.cnt == DIV_LAST) begin
              d.ref_clock_divisor = shift_in[7:0];
            end
          end
          OP_CR_WR: begin
            if (!q.wrap && q.cnt == CR_LAST) begin
              d.transmit_config = shift_in[15:0];
            end
          end
          OP_FIFO_WR: begin
            if (q.cnt == WORD_LAST) begin
              d.wr_valid = 1'b1;
              d.wr_data  = shift_in;
            end
          end
          default: ;
        endcase
      end
    end else if (fall && q.op_done) begin
      d.so = q.rd[15];
      d.rd = {q.rd[14:0], 1'b0};
    end

    if (q.mc_s[1]) begin
      d.flush = 1'b1;
      d.abort = 1'b1;
    end

    if (rst) begin
      d                   = '0;
      d.cs_s              = '1;
      d.transmit_config   = CONFIG_RST;
      d.ref_clock_divisor = DIVISOR_RST;
      d.st                = TX_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  // ===========================================================================
  // Checks
  property p_div_store;
    @(posedge clk) disable iff (rst)
      cs_act && rise && q.op_done && q.op == OP_DIV_WR && !q.wrap && q.cnt == DIV_LAST
      |=> q.ref_clock_divisor == $past(shift_in[7:0]);
  endproperty
  a_div_store: assert property (p_div_store) else $error("Divisor not stored");

  property p_bad_div;
    @(posedge clk) disable iff (rst)
      q.transmit_config[CLK_SRC_SEL] && !div_ok |-> !arinc_tick;
  endproperty
  a_bad_div: assert property (p_bad_div) else $error("Clock ran with bad divisor");

  property p_cr_store;
    @(posedge clk) disable iff (rst)
      cs_act && rise && q.op_done && q.op == OP_CR_WR && !q.wrap && q.cnt == CR_LAST
      |=> q.transmit_config == $past(shift_in[15:0]);
  endproperty
  a_cr_store: assert property (p_cr_store) else $error("Configuration not stored");

  property p_clear;
    @(posedge clk) disable iff (rst)
      cs_act && rise && !q.op_done && q.cnt == OP_LAST && shift_in[7:0] == OP_FIFO_CL
      |-> ##2 fifo_level == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("FIFO not cleared");

  property p_send_auto;
    @(posedge clk) disable iff (rst)
      cs_act && rise && !q.op_done && q.cnt == OP_LAST && shift_in[7:0] == OP_SEND
      && q.transmit_config[AUTO_SEND] && !q.go |=> !q.go;
  endproperty
  a_send_auto: assert property (p_send_auto) else $error("Send taken in auto mode");

  property p_driver_off;
    @(posedge clk) disable iff (rst)
      q.transmit_config[DRIVER_OFF] |=> !line_out_pos && !line_out_neg;
  endproperty
  a_driver_off: assert property (p_driver_off) else $error("Line driven while off");

  property p_flag;
    @(posedge clk) disable iff (rst)
      1'b1 |=> fifo_flag_pin == $past(q.transmit_config[FLAG_SELECT] ? full_bit : empty_bit);
  endproperty
  a_flag: assert property (p_flag) else $error("Flag pin wrong");

  property p_cs_abort;
    @(posedge clk) disable iff (rst)
      !cs_act |=> q.cnt == '0 && !q.op_done && !q.wr_valid;
  endproperty
  a_cs_abort: assert property (p_cs_abort) else $error("Partial field kept");

  property p_mclr_keeps;
    @(posedge clk) disable iff (rst)
      q.abort |-> q.transmit_config == $past(q.transmit_config) ##1 q.st == TX_IDLE;
  endproperty
  a_mclr_keeps: assert property (p_mclr_keeps) else $error("Master clear misbehaved");

endmodule

/* File: verif/spi_host_model.sv */
// Host side model of the serial command port
`timescale 1ns/100ps

// ============================================================================
// Serial master: select, shift and release tasks, mode 0
module spi_host_model (
  input  wire logic clk,
  input  wire logic so,
  output logic      sck,
  output logic      cs_n,
  output logic      si
);
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic start();
    @(negedge clk);
    cs_n = 1'b0;
    tick(8);
  endtask

  // Data changes while the clock is low and is held across the rise
  task automatic shift(input logic [31:0] d, input int n, output logic [31:0] q);
    q = '0;
    for (int i = n - 1; i >= 0; i--) begin
      si = d[i];
      tick(8);
      q = {q[30:0], so};
      sck = ~sck;
      tick(8);
      sck = ~sck;
    end
  endtask

  // Released data line falls to its pull-down level
  task automatic stop();
    tick(8);
    cs_n = 1'b1;
    si   = 1'b0;
    tick(8);
  endtask
endmodule

/* File: verif/arinc_tx_spi_command_regs_test.sv */
// Self-checking bench for the serial command and transmit block
`timescale 1ns/100ps

// ============================================================================
// Test sequence
module arinc_tx_spi_command_regs_test;
  import arinc_tx_pkg::*;

  logic        clk;
  logic        rst;
  logic        aclk;
  logic        master_clear;
  logic        sck;
  logic        cs_n;
  logic        si;
  logic        so;
  logic        fifo_flag_pin;
  logic        line_out_pos;
  logic        line_out_neg;
  logic        pos_q;
  logic        neg_q;
  logic [63:0] cap;
  logic [31:0] r;
  logic [7:0]  ign [0:4];
  int          stamp [0:1];
  int          nb;
  int          cyc;
  int          n_errors;
  int          checked;

  arinc_tx_spi_command_regs dut (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
    .aclk(aclk), .master_clear(master_clear), .so(so), .fifo_flag_pin(fifo_flag_pin),
    .line_out_pos(line_out_pos), .line_out_neg(line_out_neg));
  spi_host_model host (.clk(clk), .so(so), .sck(sck), .cs_n(cs_n), .si(si));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Reference clock of 10 MHz, phase unrelated to clk
  initial begin
    aclk = 1'b0;
    #1.3;
    forever #50 aclk = ~aclk;
  end

  // Records each bit start on the line, and the cycle of the first two
  always @(posedge clk) begin
    cyc++;
    pos_q <= line_out_pos;
    neg_q <= line_out_neg;
    if ((line_out_pos && !pos_q) || (line_out_neg && !neg_q)) begin
      if (nb < 64) cap[nb] <= line_out_pos;
      if (nb < 2) stamp[nb] <= cyc;
      nb <= nb + 1;
    end
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] op, input int n, input logic [31:0] d);
    host.start();
    host.shift({24'h0, op}, 8, r);
    if (n > 0) host.shift(d, n, r);
    host.stop();
  endtask

  task automatic rd(input logic [7:0] op, input int n, output logic [31:0] q);
    host.start();
    host.shift({24'h0, op}, 8, q);
    host.shift(32'h0, n, q);
    host.stop();
  endtask

  task automatic load(input int n, input logic [31:0] w);
    host.start();
    host.shift({24'h0, OP_FIFO_WR}, 8, r);
    for (int k = 0; k < n; k++) host.shift(w + k, 32, r);
    host.stop();
  endtask

  task automatic status(input logic [7:0] exp, input string msg);
    rd(OP_SR_RD, 8, r);
    chk(r, {24'h0, exp}, msg);
  endtask

  // Line order of a word: index k is line bit k+1
  function automatic logic [31:0] arinc(input logic [31:0] w, input logic [15:0] c);
    logic [31:0] a;
    a = w;
    for (int i = 0; i < 8; i++) a[i] = c[LABEL_ORDER] ? w[i] : w[7-i];
    if (c[PARITY_ENABLE]) a[31] = ~(^a[30:0]) ^ c[PARITY_SENSE];
    return a;
  endfunction

  task automatic xmit(input logic [31:0] w, input logic [15:0] c, input int per);
    wr(OP_CR_WR, 16, {16'h0, c});
    nb = 0;
    load(2, w);
    if (!c[AUTO_SEND]) begin
      host.tick(300);
      chk(nb, 0, "held until send");
      wr(OP_SEND, 0, 32'h0);
    end
    for (int t = 0; t < 2000 && nb < 1; t++) host.tick(1);
    status(8'h00, "sending");
    for (int t = 0; t < 40000 && nb < 64; t++) host.tick(1);
    chk(cap, {arinc(w + 1, c), arinc(w, c)}, "line bits");
    chk((stamp[1] - stamp[0]) > per - 5 && (stamp[1] - stamp[0]) < per + 5, 1, "period");
    host.tick(5 * per);
    status(8'h08, "all sent");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #480_000;
    n_errors++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    rst          = 1'b1;
    master_clear = 1'b0;
    pos_q        = 1'b0;
    neg_q        = 1'b0;
    cap          = '0;
    nb           = 0;
    cyc          = 0;
    n_errors     = 0;
    checked      = 0;
    ign          = '{8'h00, 8'h0f, 8'h08, 8'h09, 8'h0d};
    repeat (20) @(negedge clk);
    rst = 1'b0;
    host.tick(10);
    rd(OP_CR_RD, 16, r);
    chk(r, {16'h0, CONFIG_RST}, "config reset");
    rd(OP_DIV_RD, 8, r);
    chk(r, {24'h0, DIVISOR_RST}, "divisor reset");
    status(8'h08, "reset status");
    chk(fifo_flag_pin, 1'b1, "flag empty");
    $display("test reset done");
    wr(OP_DIV_WR, 8, 32'h0a);
    rd(OP_DIV_RD, 8, r);
    chk(r, 32'h0a, "divisor");
    wr(OP_CR_WR, 16, 32'h9e5b);
    rd(OP_CR_RD, 16, r);
    chk(r, 32'h9e5b, "config");
    foreach (ign[i]) begin
      host.start();
      host.shift({24'h0, ign[i]}, 8, r);
      host.shift(32'hffff, 16, r);
      host.stop();
      chk(r, 32'h0, "ignored op output");
    end
    host.start();
    host.shift({24'h0, OP_CR_WR}, 8, r);
    host.shift(32'h3ff, 10, r);
    host.stop();
    rd(OP_CR_RD, 16, r);
    chk(r, 32'h9e5b, "config untouched");
    $display("test registers done");
    wr(OP_CR_WR, 16, 32'h4000);
    host.start();
    host.shift({24'h0, OP_FIFO_WR}, 8, r);
    host.shift(32'h12345, 20, r);
    host.stop();
    status(8'h08, "partial word");
    load(16, 32'h100);
    status(8'h10, "half");
    chk(fifo_flag_pin, 1'b0, "flag not full");
    load(17, 32'h200);
    status(8'h30, "full");
    chk(fifo_flag_pin, 1'b1, "flag full");
    wr(OP_FIFO_CL, 0, 32'h0);
    status(8'h08, "cleared fifo");
    chk(fifo_flag_pin, 1'b0, "flag after clear");
    $display("test fifo done");
    for (int k = 0; k < 2; k++) begin
      wr(OP_DIV_WR, 8, k ? 32'h01 : 32'h03);
      wr(OP_CR_WR, 16, k ? 32'h3000 : 32'h2002);
      nb = 0;
      load(2, 32'h5);
      host.tick(3000);
      chk(nb, 0, "line quiet");
      if (k) begin
        master_clear = 1'b1;
        host.tick(10);
        master_clear = 1'b0;
        host.tick(10);
      end else begin
        wr(OP_MCLR, 0, 32'h0);
      end
      status(8'h08, "master clear");
    end
    rd(OP_CR_RD, 16, r);
    chk(r, 32'h3000, "config kept");
    $display("test clear done");
    xmit(32'h8000_0103, 16'h0008, 200);
    wr(OP_DIV_WR, 8, 32'h02);
    xmit(32'h4000_0a81, 16'h2a0a, 400);
    $display("test transmit done");
    test_done();
  end
endmodule
